// ===== hdl/pbs_pkg.sv
// Purpose: shared constants for the push button power sequencer
// Assumes: 50 MHz system clock, all timers count 1 ms ticks
// Notes:   durations are in ms; the per-ms cycle count is a top parameter

// ==========================================================================
// package
package pbs_pkg;

  // clock rate and derived ms tick length
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned MS_PER_S     = 1000;
  localparam int unsigned MS_CYCLES    = CLK_HZ / MS_PER_S;  // 50000 cycles

  // timer widths
  localparam int          TMR_W        = 10;   // up to 1023 ms
  localparam int          EXT_W        = 8;    // extension inputs, ms
  localparam int          DIV_W        = 16;   // ms divider counter

  // documented durations, in ms
  localparam logic [9:0]  ON_DEBOUNCE_MS  = 10'h080;  // 128 ms
  localparam logic [9:0]  BLANKING_MS     = 10'h200;  // 512 ms
  localparam logic [9:0]  OFF_DEBOUNCE_MS = 10'h020;  // 32 ms
  localparam logic [9:0]  RELEASE_MS      = 10'h020;  // 32 ms
  localparam logic [9:0]  FAILSAFE_MS     = 10'h080;  // 128 ms
  localparam logic [9:0]  LOCKOUT_MS      = 10'h100;  // 256 ms

  // sequencer states
  typedef enum logic [2:0] {
    ST_REL_OFF,    // waiting for button release before arming
    ST_OFF,        // off, debouncing a turn-on press
    ST_BLANK,      // enabled, shutdown request and button ignored
    ST_REL_ON,     // enabled, debouncing button release
    ST_ON,         // powered on, watching for turn-off
    ST_FAILSAFE,   // interrupt raised, waiting for processor
    ST_LOCKOUT     // enable released, button ignored
  } pbs_state_t;

endpackage : pbs_pkg

// ===== hdl/pbs_tmr_if.sv
// Purpose: carries timer control and status between sequencer and timer
// Assumes: one clock domain
// Notes:   clr restarts the count on any state change

`timescale 1ns/1ps

// ==========================================================================
// interface
interface pbs_tmr_if;
  logic       tick;    // 1 ms enable pulse
  logic       run;     // count while high, hold zero while low
  logic       clr;     // restart count
  logic [9:0] limit;   // duration in ms
  logic       done;    // count reached limit

  modport ctl (output tick, output run, output clr, output limit, input done);
  modport tmr (input tick, input run, input clr, input limit, output done);
endinterface : pbs_tmr_if

// ===== hdl/pbs_timer.sv
// Purpose: ms timer used for every debounce, blanking and lockout delay
// Assumes: tick is a one-cycle pulse once per ms
// Notes:   done is level and stays high until run drops or clr pulses

`timescale 1ns/1ps

// ==========================================================================
// timer
module pbs_timer
  import pbs_pkg::*;
(
  input  wire logic mclk_in,      // system clock
  input  wire logic reset_n_in,   // sync reset, active low
  pbs_tmr_if.tmr    t             // control from the sequencer
);

  logic [TMR_W-1:0] count;

  // count stops at the limit so done cannot wrap away
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in || t.clr || !t.run)
      count <= '0;
    else if (t.tick && (count < t.limit))
      count <= count + 10'h001;
  end

  // done must not look at clr: clr is formed from done, which would loop
  assign t.done = t.run && (count >= t.limit);

endmodule : pbs_timer

// ===== hdl/pbs_sequencer.sv
// Purpose: push button power on/off sequencer with processor handshake
// Assumes: button and shutdown request arrive asynchronously from pins
// Notes:   extension inputs are static straps in ms, sampled continuously
//
// Overview of operation
// RQ1: enable deasserted and converter off after reset
// RQ2: enable only after 128ms continuous low press
// RQ3: button high resets any running debounce
// RQ4: 512ms blanking ignores button and shutdown request
// RQ5: shutdown request low at blank end aborts
// RQ6: 32ms release debounce after blanking, then on
// RQ7: turn-off needs low for 32ms plus extension
// RQ8: off extension configurable, zero gives 32ms
// RQ9: valid turn-off press drives interrupt low
// RQ10: failsafe 128ms plus extension then release enable
// RQ11: shutdown request during failsafe releases enable at once
// RQ12: shutdown request low after blanking releases enable
// RQ13: enable polarity fixed per variant
// RQ14: after off, debounce release then rearm
// RQ15: processor may tie interrupt to shutdown request
// RQ16: 256ms button lockout after enable release
// RQ17: interrupt released when sequencer returns off
// RQ18: all timers are counters on one clock

`timescale 1ns/1ps

// ==========================================================================
// top module
module pbs_sequencer
  import pbs_pkg::*;
#(
  parameter int unsigned MS_CYC     = MS_CYCLES,  // cycles per ms tick
  parameter bit          EN_ACT_HI  = 1'b1        // 1: high-true enable
)
(
  input  wire logic             mclk_in,                  // 50 MHz clock
  input  wire logic             reset_n_in,               // sync reset
  input  wire logic             button_in_n,              // push button
  input  wire logic             shutdown_req_n_in,        // processor request
  input  wire logic [EXT_W-1:0] off_debounce_extend_in,   // extra off, ms
  input  wire logic [EXT_W-1:0] failsafe_delay_extend_in, // extra fail, ms
  output logic                  en_out,                   // power enable
  output logic                  int_n_out                 // interrupt
);

  // ========================================================================
  // input synchronisers
  logic             btn_s1;
  logic             btn_s2;
  logic             req_s1;
  logic             req_s2;
  logic [EXT_W-1:0] offx_s1;
  logic [EXT_W-1:0] offx_s2;
  logic [EXT_W-1:0] offx_s3;
  logic [EXT_W-1:0] offx_q;
  logic [EXT_W-1:0] fsx_s1;
  logic [EXT_W-1:0] fsx_s2;
  logic [EXT_W-1:0] fsx_s3;
  logic [EXT_W-1:0] fsx_q;

  // button pin is async; two flops before any decision reads it
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      btn_s1 <= 1'b1;
      btn_s2 <= 1'b1;
    end
    else
    begin
      btn_s1 <= button_in_n;
      btn_s2 <= btn_s1;
    end
  end

  // request resets to idle high so reset itself never looks like a request
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      req_s1 <= 1'b1;
      req_s2 <= 1'b1;
    end
    else
    begin
      req_s1 <= shutdown_req_n_in;
      req_s2 <= req_s1;
    end
  end

  // straps are static but off-domain, so they pass the flops as well
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      offx_s1 <= '0;
      offx_s2 <= '0;
      offx_s3 <= '0;
      fsx_s1  <= '0;
      fsx_s2  <= '0;
      fsx_s3  <= '0;
    end
    else
    begin
      offx_s1 <= off_debounce_extend_in;
      offx_s2 <= offx_s1;
      offx_s3 <= offx_s2;
      fsx_s1  <= failsafe_delay_extend_in;
      fsx_s2  <= fsx_s1;
      fsx_s3  <= fsx_s2;
    end
  end

  // a moving strap word can be caught half old, half new; only a value
  // seen on two edges in a row is taken, so a limit never jumps
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      offx_q <= '0;
      fsx_q  <= '0;
    end
    else
    begin
      if (offx_s2 == offx_s3)
        offx_q <= offx_s3;
      if (fsx_s2 == fsx_s3)
        fsx_q <= fsx_s3;
    end
  end

  logic btn_low;
  logic req_low;

  assign btn_low = !btn_s2;
  assign req_low = !req_s2;

  // ========================================================================
  // ms tick divider
  logic [DIV_W-1:0] div_cnt;
  logic             ms_tick;

  // one enable pulse per ms; every timer shares it
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      div_cnt <= '0;
      ms_tick <= 1'b0;
    end
    else if (div_cnt == DIV_W'(MS_CYC - 1))
    begin
      div_cnt <= '0;
      ms_tick <= 1'b1;
    end
    else
    begin
      div_cnt <= div_cnt + 16'h0001;
      ms_tick <= 1'b0;
    end
  end

  // ========================================================================
  // shared timer
  pbs_tmr_if  tmr_bus ();

  pbs_timer u_timer (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .t          (tmr_bus.tmr)
  );

  // base plus a strap extension, widened to timer width
  function automatic logic [TMR_W-1:0] ext_limit(input logic [9:0]       base,
                                                 input logic [EXT_W-1:0] ext);
    ext_limit = base + {2'h0, ext};
  endfunction : ext_limit

  // ========================================================================
  // sequencer state machine
  // delays are whole ms ticks of a free running divider, so the first tick
  // of any delay can land anywhere in its first ms: an N ms delay lasts
  // between N-1 and N ms, plus sync and output flop cycles
  // one shared timer serves every state; a state change clears it so no
  // delay inherits a partial count from the state before
  pbs_state_t state;
  pbs_state_t next_state;
  logic       tmr_run;
  logic [9:0] tmr_limit;

  // next state and timer steering per state
  always_comb
  begin
    next_state = state;
    tmr_run    = 1'b0;
    tmr_limit  = RELEASE_MS;
    case (state)
      ST_REL_OFF:
      begin
        tmr_run   = !btn_low;                          // see RQ14
        tmr_limit = RELEASE_MS;
        if (tmr_bus.done)
          next_state = ST_OFF;                         // see RQ14
      end
      ST_OFF:
      begin
        tmr_run   = btn_low;                           // see RQ3
        tmr_limit = ON_DEBOUNCE_MS;
        if (tmr_bus.done)
          next_state = ST_BLANK;                       // see RQ2
      end
      ST_BLANK:
      begin
        // button deliberately not looked at here; request read only at blank end
        tmr_run   = 1'b1;                              // see RQ4
        tmr_limit = BLANKING_MS;
        if (tmr_bus.done && req_low)
          next_state = ST_LOCKOUT;                     // see RQ5
        else if (tmr_bus.done)
          next_state = ST_REL_ON;
      end
      ST_REL_ON:
      begin
        tmr_run   = !btn_low;                          // see RQ6
        tmr_limit = RELEASE_MS;
        if (req_low)
          next_state = ST_LOCKOUT;                     // see RQ12
        else if (tmr_bus.done)
          next_state = ST_ON;                          // see RQ6
      end
      ST_ON:
      begin
        tmr_run   = btn_low;                           // see RQ3
        tmr_limit = ext_limit(OFF_DEBOUNCE_MS, offx_q);  // see RQ7 RQ8
        if (req_low)
          next_state = ST_LOCKOUT;                     // see RQ12
        else if (tmr_bus.done)
          next_state = ST_FAILSAFE;                    // see RQ7
      end
      ST_FAILSAFE:
      begin
        tmr_run   = 1'b1;
        tmr_limit = ext_limit(FAILSAFE_MS, fsx_q);     // see RQ10
        // request or timeout, whichever comes first; both end in the same place
        if (req_low || tmr_bus.done)
          next_state = ST_LOCKOUT;                     // see RQ10 RQ11
      end
      ST_LOCKOUT:
      begin
        tmr_run   = 1'b1;                              // see RQ16
        tmr_limit = LOCKOUT_MS;
        if (tmr_bus.done)
          next_state = ST_REL_OFF;                     // see RQ16
      end
      default:
      begin
        next_state = ST_REL_OFF;
      end
    endcase
  end

  // timer restarts whenever the state moves
  assign tmr_bus.tick  = ms_tick;                      // see RQ18
  assign tmr_bus.run   = tmr_run;
  assign tmr_bus.limit = tmr_limit;
  assign tmr_bus.clr   = (next_state != state);

  // reset lands in release wait so a held button cannot power on
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
      state <= ST_REL_OFF;                             // see RQ1
    else
      state <= next_state;
  end

  // ========================================================================
  // outputs, registered from the next state
  logic next_en_on;
  logic next_int_on;

  // states in which the converter is powered
  function automatic logic powered(input pbs_state_t s);
    powered = (s == ST_BLANK) || (s == ST_REL_ON) || (s == ST_ON) ||
              (s == ST_FAILSAFE);
  endfunction : powered

  assign next_en_on  = powered(next_state);
  assign next_int_on = (next_state == ST_FAILSAFE);

  // enable polarity is a build-time variant choice
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
      en_out <= !EN_ACT_HI;                            // see RQ1 RQ13
    else
      en_out <= EN_ACT_HI ? next_en_on : !next_en_on;  // see RQ13
  end

  // interrupt low only while the failsafe window runs
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
      int_n_out <= 1'b1;
    else
      int_n_out <= !next_int_on;                       // see RQ9 RQ17
  end

endmodule : pbs_sequencer

// ===== bench/pbs_sequencer_props.sv
// Purpose: port checker for pbs_sequencer
// Assumes: one clock, sync reset held 2+ cycles
// Notes:   run-length counters tie outputs to their causes
`timescale 1ns/1ps
// ==========================================================================
// checker
module pbs_sequencer_props
  import pbs_pkg::*;
#(
  parameter int unsigned MS_CYC    = MS_CYCLES, // cycles per ms
  parameter bit          EN_ACT_HI = 1'b1       // enable polarity
)
(
  input wire logic             mclk_in,                  // clock
  input wire logic             reset_n_in,               // reset
  input wire logic             button_in_n,              // button
  input wire logic             shutdown_req_n_in,        // request
  input wire logic [EXT_W-1:0] off_debounce_extend_in,   // off ext
  input wire logic [EXT_W-1:0] failsafe_delay_extend_in, // fail ext
  input wire logic             en_out,                   // enable
  input wire logic             int_n_out                 // interrupt
);
  logic        en_on;
  logic        rst_d;
  int unsigned bl_cnt, on_cnt, off_cnt, il_cnt;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  // enable asserted, whichever polarity
  assign en_on = (en_out == EN_ACT_HI);
  // no reset here, so it still sees the release edge
  always_ff @(posedge mclk_in) rst_d <= !reset_n_in;
  // run lengths; off_cnt starts high since reset needs no lockout
  always_ff @(posedge mclk_in)
    if (!reset_n_in)
    begin
      bl_cnt  <= 0;
      on_cnt  <= 0;
      off_cnt <= 32'h00ffffff;
      il_cnt  <= 0;
    end
    else
    begin
      bl_cnt  <= button_in_n ? 0 : bl_cnt + 1;
      on_cnt  <= en_on ? on_cnt + 1 : 0;
      off_cnt <= en_on ? 0 : off_cnt + 1;
      il_cnt  <= int_n_out ? 0 : il_cnt + 1;
    end
  AST_RESET_OFF: assert property (rst_d |-> !en_on && int_n_out)
    else $error("outputs active after reset");
  AST_ON_DEBOUNCE: assert property ($rose(en_on) |-> $past(bl_cnt, 4) >= 126 * MS_CYC)
    else $error("enable without full press");
  AST_OFF_DEBOUNCE: assert property ($fell(int_n_out) |->
    $past(bl_cnt, 4) >= (31 + off_debounce_extend_in) * MS_CYC) else $error("early interrupt");
  AST_BLANK_HOLD: assert property ($fell(en_on) |-> $past(on_cnt) >= 511 * MS_CYC)
    else $error("enable dropped in blanking");
  AST_REQ_RELEASE: assert property (en_on && on_cnt > 513 * MS_CYC + 4 &&
    !shutdown_req_n_in |-> ##[1:4] !en_on) else $error("request ignored");
  AST_INT_NEEDS_EN: assert property (!int_n_out |-> en_on)
    else $error("interrupt while off");
  AST_INT_RELEASE: assert property ($fell(en_on) |-> int_n_out)
    else $error("interrupt kept after release");
  AST_FAILSAFE_MAX: assert property (il_cnt <= (129 + failsafe_delay_extend_in) * MS_CYC + 4)
    else $error("failsafe overran");
  AST_LOCKOUT: assert property ($rose(en_on) |-> $past(off_cnt) >= 412 * MS_CYC)
    else $error("enable inside lockout");
endmodule : pbs_sequencer_props
bind pbs_sequencer pbs_sequencer_props #(.MS_CYC(MS_CYC), .EN_ACT_HI(EN_ACT_HI))
  u_pbs_sequencer_props (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
  .button_in_n(button_in_n), .shutdown_req_n_in(shutdown_req_n_in),
  .off_debounce_extend_in(off_debounce_extend_in),
  .failsafe_delay_extend_in(failsafe_delay_extend_in), .en_out(en_out), .int_n_out(int_n_out));

// ===== bench/pbs_cpu_model.sv
// Purpose: processor on the far side of the sequencer
// Assumes: request reads low while the processor is unpowered
// Notes:   modes 0 slow answer, 1 mute, 2 never boots, 3 tied
`timescale 1ns/1ps
// ==========================================================================
// model
module pbs_cpu_model
#(
  parameter int unsigned BOOT = 400, // cycles until request high
  parameter int unsigned RESP = 40   // cycles to answer interrupt
)
(
  input  wire logic       mclk_in,  // clock
  input  wire logic       en_on_in, // power present
  input  wire logic       int_n_in, // interrupt
  input  wire logic [1:0] mode_in,  // behaviour
  input  wire logic       kill_in,  // request power off now
  output logic            req_n_out // shutdown request
);
  logic        req   = 1'b0;
  logic        int_d = 1'b1;
  int unsigned cnt   = 0;
  // cycles since power came or interrupt moved
  always_ff @(posedge mclk_in)
  begin
    int_d <= int_n_in;
    cnt   <= (!en_on_in || int_d != int_n_in) ? 0 : cnt + 1;
  end
  // latched low until power goes, as a hung processor would
  always_ff @(posedge mclk_in)
    if (!en_on_in || kill_in)
      req <= 1'b0;
    else if (int_n_in && mode_in != 2'h2 && cnt == BOOT)
      req <= 1'b1;
    else if (!int_n_in && mode_in == 2'h0 && cnt == RESP)
      req <= 1'b0;
  // tied mode: interrupt drives the request at once
  assign req_n_out = (mode_in == 2'h3) ? (req & int_n_in) : req;
endmodule : pbs_cpu_model

// ===== bench/pbs_sequencer_tb.sv
// Purpose: self-checking bench for pbs_sequencer
// Assumes: 4 cycles per ms tick
// Notes:   checks keep a few ms margin for tick jitter
`timescale 1ns/1ps
// ==========================================================================
// bench
module pbs_sequencer_tb;
  import pbs_pkg::*;
  localparam int unsigned MS = 4;
  logic             mclk_in     = 1'b0;
  logic             reset_n_in  = 1'b0;
  logic             button_in_n = 1'b1;
  logic             kill        = 1'b0;
  logic [1:0]       mode        = 2'h0;
  logic [EXT_W-1:0] off_ext     = 8'h00;
  logic [EXT_W-1:0] fs_ext      = 8'h00;
  logic             req_n, en_out, en_lo, int_n_out;
  int               err_count = 0;
  int               n_checks  = 0;
  int               seed      = 32'h2667b402;
  int               k;
  pbs_sequencer #(.MS_CYC(MS), .EN_ACT_HI(1'b1)) u_pbs_sequencer (.mclk_in(mclk_in),
    .reset_n_in(reset_n_in), .button_in_n(button_in_n), .shutdown_req_n_in(req_n),
    .off_debounce_extend_in(off_ext), .failsafe_delay_extend_in(fs_ext),
    .en_out(en_out), .int_n_out(int_n_out));
  pbs_sequencer #(.MS_CYC(MS), .EN_ACT_HI(1'b0)) u_pbs_sequencer_n (.mclk_in(mclk_in),
    .reset_n_in(reset_n_in), .button_in_n(button_in_n), .shutdown_req_n_in(req_n),
    .off_debounce_extend_in(off_ext), .failsafe_delay_extend_in(fs_ext),
    .en_out(en_lo), .int_n_out());
  pbs_cpu_model u_pbs_cpu_model (.mclk_in(mclk_in), .en_on_in(en_out === 1'b1),
    .int_n_in(int_n_out), .mode_in(mode), .kill_in(kill), .req_n_out(req_n));
  initial forever #10 mclk_in = ~mclk_in;
  task automatic ms(input int n);
    repeat (n * MS) @(negedge mclk_in);
  endtask : ms
  task automatic chk(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask : chk
  function automatic int off_ms(input logic [EXT_W-1:0] e);
    return 32 + int'(e);
  endfunction : off_ms
  function automatic int fail_ms(input logic [EXT_W-1:0] e);
    return 128 + int'(e);
  endfunction : fail_ms
  // press held well into blanking, where it must be ignored
  task automatic power_on();
    button_in_n = 1'b0;
    ms(125);
    chk(en_out, 1'b0, "en early");
    ms(5);
    chk(en_out, 1'b1, "en late");
    ms(400);
    button_in_n = 1'b1;
    ms(160);
    chk(en_out, 1'b1, "en lost in blanking");
  endtask : power_on
  task automatic turn_off();
    button_in_n = 1'b0;
    ms(off_ms(off_ext) - 2);
    chk(int_n_out, 1'b1, "int early");
    ms(4);
    button_in_n = 1'b1;
  endtask : turn_off
  task automatic summarize();
    $display("checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  // both polarity variants must agree every cycle
  always @(negedge mclk_in) if (reset_n_in) chk(en_lo, ~en_out, "polarity");
  // hang guard, well past the planned run
  initial
  begin
    repeat (9000 * MS) @(posedge mclk_in);
    err_count++;
    summarize();
  end
  initial
  begin
    repeat (2) @(negedge mclk_in);
    reset_n_in = 1'b1;
    chk(en_out, 1'b0, "en after reset");
    chk(int_n_out, 1'b1, "int after reset");
    ms(40);
    // back-to-back short presses, each release restarts the count
    for (k = 0; k < 4; k++)
    begin
      button_in_n = 1'b0;
      ms(20 + ($unsigned($random(seed)) % 100));
      button_in_n = 1'b1;
      ms(2);
      chk(en_out, 1'b0, "en on short press");
    end
    $display("test short presses done");
    // default and random turn-off extension, then a lockout press
    for (k = 0; k < 2; k++)
    begin
      off_ext = 8'h00;
      if (k == 1) off_ext = EXT_W'($random(seed) & 32'h0000000f);
      power_on();
      turn_off();
      chk(int_n_out, 1'b0, "int missing");
      ms(15);
      chk(en_out, 1'b0, "en after request");
      chk(int_n_out, 1'b1, "int kept");
      // released long enough to arm, so only the lockout can refuse this
      ms(40);
      button_in_n = 1'b0;
      ms(200);
      button_in_n = 1'b1;
      ms(100);
      chk(en_out, 1'b0, "en after lockout press");
      $display("test power cycle %0d done", k);
    end
    // processor never answers
    mode = 2'h1;
    fs_ext = EXT_W'($random(seed) & 32'h0000001f);
    power_on();
    turn_off();
    ms(fail_ms(fs_ext) - 6);
    chk(en_out, 1'b1, "en before failsafe");
    ms(8);
    chk(en_out, 1'b0, "en after failsafe");
    ms(300);
    $display("test failsafe done");
    // request in normal running
    mode = 2'h0;
    power_on();
    kill = 1'b1;
    ms(1);
    kill = 1'b0;
    chk(en_out, 1'b0, "en after run request");
    ms(300);
    $display("test run request done");
    // interrupt wired to request
    mode = 2'h3;
    power_on();
    turn_off();
    chk(en_out, 1'b0, "en with tied request");
    ms(300);
    $display("test tied done");
    // request never raised: power-on aborts
    mode = 2'h2;
    button_in_n = 1'b0;
    ms(130);
    button_in_n = 1'b1;
    ms(500);
    chk(en_out, 1'b1, "en in blanking");
    ms(20);
    chk(en_out, 1'b0, "en after abort");
    ms(300);
    $display("test abort done");
    // reset in mid-run
    mode = 2'h0;
    power_on();
    reset_n_in = 1'b0;
    repeat (2) @(negedge mclk_in);
    chk(en_out, 1'b0, "en in reset");
    reset_n_in = 1'b1;
    repeat (2) @(negedge mclk_in);
    chk(en_out, 1'b0, "en after mid reset");
    chk(int_n_out, 1'b1, "int after mid reset");
    $display("test mid reset done");
    summarize();
  end
endmodule : pbs_sequencer_tb
